// *** rtl/mss_defs.svh ***
// Purpose: constants of the motor speed supervisor
// Assumes: 250 MHz hclk, 32-bit AHB-Lite register words
// Notes:   offsets are byte addresses, timing counts derive from times
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
`define MSS_CLK_HZ          250000000
`define MSS_MSG_TIME_MS     1000
`define MSS_MSG_CYC         ((`MSS_CLK_HZ / 1000) * `MSS_MSG_TIME_MS)
`define MSS_IDLE_TIME_MS    5000
`define MSS_IDLE_CYC        ((`MSS_CLK_HZ / 1000) * `MSS_IDLE_TIME_MS)
`define MSS_LOCK_TIME_MS    5000
`define MSS_LOCK_CYC        ((`MSS_CLK_HZ / 1000) * `MSS_LOCK_TIME_MS)
`define MSS_RAMP_FIX_DS     10
`define MSS_RAMP_MIN_DS     1
`define MSS_RAMP_MAX_DS     150
`define MSS_RAMP_REF_RPM    1000
`define MSS_SPD_MIN         16'd90
`define MSS_SPD_MAX         16'd1600
`define MSS_CTRL_OFF        32'h00
`define MSS_SETPT_OFF       32'h04
`define MSS_UPPER_OFF       32'h08
`define MSS_LOWER_OFF       32'h0c
`define MSS_RATIO_OFF       32'h10
`define MSS_STAT_OFF        32'h14
`define MSS_DISP_OFF        32'h18
`define MSS_ALRST_OFF       32'h1c
`define MSS_CTRL_LOCK_BIT   0
`define MSS_CTRL_EXT_BIT    1
`define MSS_CTRL_RAMP_BIT   2
`define MSS_CTRL_PONP_BIT   3
`define MSS_CTRL_RST        4'h8
`define MSS_SETPT_RST       16'd1000
`define MSS_RATIO_RST       20'd100
`endif

// *** rtl/mss_pkg.sv ***
// Purpose: types of the motor speed supervisor
// Assumes: nothing beyond the defs header
// Notes:   display modes and alarm codes
package mss_pkg;
  typedef enum logic [2:0] {
    MSS_D_NORM = 3'b000, MSS_D_LOCK = 3'b001, MSS_D_EXT = 3'b011,
    MSS_D_ERR = 3'b010, MSS_D_ALM = 3'b110
  } mss_disp_t;
  typedef enum logic [2:0] {
    MSS_A_NONE = 3'h0, MSS_A_HEAT = 3'h1, MSS_A_LOCK = 3'h2,
    MSS_A_NVM = 3'h3, MSS_A_PON = 3'h4
  } mss_alarm_t;
endpackage

// *** rtl/mss_top.sv ***
// Purpose: supervisory logic of an ac motor speed controller
// Assumes: synchronous panel and link inputs, one clock, ahb-lite slave
// Notes:   speed values in r/min, ratio in hundredths
// Function
// - lock ignores changes, still allows viewing
// - locked change shows lock warning 1 s
// - decimal point placed by ratio range
// - displayed speed is shaft speed over ratio
// - ramp off means fixed 1 s ramp
// - ramp on uses pot, 0.1 to 15 s
// - ramp time measured against 1000 r/min
// - upper limit below setpoint overwrites setpoint
// - lower limit above setpoint overwrites setpoint
// - external mode panel switches show indication
// - forward xor reverse decides external run
// - alarm cuts drive and blinks code
// - alarm display returns after 5 s idle
// - shaft locked 5 s raises lock alarm
// - memory fault raises memory alarm
// - power-on protection alarms on active run
// - power-on alarm clears when inputs release
// - overheat alarm latches until cleared
// - reset refused while run switch on
// - external reset refused while input on
// - power cycle clears latched alarms
// - limits accepted only 90 to 1600
// - external mode selects input source
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "mss_defs.svh"
module mss_top
  import mss_pkg::*;
#(
  parameter int unsigned MSG_CYC  = `MSS_MSG_CYC,
  parameter int unsigned IDLE_CYC = `MSS_IDLE_CYC,
  parameter int unsigned LOCK_CYC = `MSS_LOCK_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // front panel
  input  wire logic        panel_run_sw,
  input  wire logic        panel_dir_sw,
  input  wire logic        key_activity,
  input  wire logic        dial_change,
  input  wire logic [15:0] dial_value,
  input  wire logic [7:0]  ramp_pot,
  // external link
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  // motor side
  input  wire logic        thermal_open,
  input  wire logic        shaft_locked,
  input  wire logic        feedback_lost,
  input  wire logic        nvm_fault,
  input  wire logic [15:0] shaft_speed,
  // outputs
  output logic             drive_enable,
  output logic             drive_reverse,
  output logic [15:0]      ramp_time_ds,
  output logic [15:0]      disp_value,
  output logic [1:0]       disp_point,
  output logic [2:0]       disp_mode,
  output logic [2:0]       alarm_code,
  output logic             alarm_blink
);
  // registers
  logic [3:0]  ctrl_r;        // lock, ext, ramp, power-on protect
  logic [15:0] setpt_r;       // speed setpoint
  logic [15:0] upper_r;       // upper limit
  logic [15:0] lower_r;       // lower limit
  logic [19:0] ratio_r;       // reduction ratio, hundredths
  mss_alarm_t  alarm_r;       // latched alarm
  mss_disp_t   msg_r;         // transient message
  logic [31:0] msg_cnt_r;     // message timer
  logic [31:0] idle_cnt_r;    // key inactivity timer
  logic [31:0] lock_cnt_r;    // locked-shaft timer
  logic        pon_done_r;    // power-on check done
  logic        run_q_r;       // previous run switch
  logic        dir_q_r;       // previous direction switch
  logic        dir_r;         // panel direction
  // bus phase capture
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_r;
  logic [31:0] rdata_nxt;
  // events
  logic        alrst_req;     // software alarm reset pulse
  logic        rst_bad;       // reset refused
  logic        panel_poke;    // panel switch moved
  logic        ext;
  logic        ext_run;
  logic        run_cmd;
  logic [15:0] wval;
  logic        locked_try;

  assign ext  = ctrl_r[`MSS_CTRL_EXT_BIT];
  assign wval = hwdata[15:0];

  // ahb slave: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      rd_pend_r <= hsel && htrans[1] && !hwrite;
      addr_r    <= haddr[7:0];
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata_nxt = 32'h0;
    case ({24'h0, haddr[7:0]})
      `MSS_CTRL_OFF:  rdata_nxt = {28'h0, ctrl_r};
      `MSS_SETPT_OFF: rdata_nxt = {16'h0, setpt_r};
      `MSS_UPPER_OFF: rdata_nxt = {16'h0, upper_r};
      `MSS_LOWER_OFF: rdata_nxt = {16'h0, lower_r};
      `MSS_RATIO_OFF: rdata_nxt = {12'h0, ratio_r};
      `MSS_STAT_OFF:  rdata_nxt = {24'h0, run_cmd, drive_reverse, disp_mode, alarm_r};
      `MSS_DISP_OFF:  rdata_nxt = {14'h0, disp_point, disp_value};
      default:        rdata_nxt = 32'h0;
    endcase
  end

  // read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  // also: writes of settings count as dial changes
  wire wr_set = wr_pend_r && (addr_r == `MSS_SETPT_OFF || addr_r == `MSS_UPPER_OFF ||
                addr_r == `MSS_LOWER_OFF || addr_r == `MSS_RATIO_OFF);
  assign locked_try = ctrl_r[`MSS_CTRL_LOCK_BIT] && (dial_change || wr_set);
  assign alrst_req  = wr_pend_r && (addr_r == `MSS_ALRST_OFF) && hwdata[0];

  // control register, lock bit itself stays writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MSS_CTRL_RST;
    end else if (wr_pend_r && addr_r == `MSS_CTRL_OFF) begin
      ctrl_r <= hwdata[3:0];
    end
  end

  // limits and ratio
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_r <= `MSS_SPD_MAX;
      lower_r <= `MSS_SPD_MIN;
      ratio_r <= `MSS_RATIO_RST;
    end else if (wr_pend_r && !ctrl_r[`MSS_CTRL_LOCK_BIT]) begin
      if (addr_r == `MSS_UPPER_OFF && wval >= `MSS_SPD_MIN && wval <= `MSS_SPD_MAX
          && wval >= lower_r) begin
        upper_r <= wval;
      end
      if (addr_r == `MSS_LOWER_OFF && wval >= `MSS_SPD_MIN && wval <= `MSS_SPD_MAX
          && wval <= upper_r) begin
        lower_r <= wval;
      end
      if (addr_r == `MSS_RATIO_OFF && hwdata[19:0] >= `MSS_RATIO_RST) begin
        ratio_r <= hwdata[19:0];
      end
    end
  end

  // setpoint with clamping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpt_r <= `MSS_SETPT_RST;
    end else if (setpt_r > upper_r) begin
      setpt_r <= upper_r;
    end else if (setpt_r < lower_r) begin
      setpt_r <= lower_r;
    end else if (!ctrl_r[`MSS_CTRL_LOCK_BIT]) begin
      if (dial_change) begin
        setpt_r <= (dial_value > upper_r) ? upper_r :
                   (dial_value < lower_r) ? lower_r : dial_value;
      end else if (wr_pend_r && addr_r == `MSS_SETPT_OFF) begin
        setpt_r <= (wval > upper_r) ? upper_r : (wval < lower_r) ? lower_r : wval;
      end
    end
  end

  // panel switch edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q_r <= 1'b0;
      dir_q_r <= 1'b0;
    end else begin
      run_q_r <= panel_run_sw;
      dir_q_r <= panel_dir_sw;
    end
  end
  assign panel_poke = (panel_run_sw ^ run_q_r) || (panel_dir_sw ^ dir_q_r);

  // panel direction follows switch only in panel mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= 1'b0;
    end else if (!ext) begin
      dir_r <= panel_dir_sw;
    end
  end

  assign ext_run = forward_run_input ^ reverse_run_input;
  assign run_cmd = ext ? ext_run : panel_run_sw;

  assign rst_bad = alrst_req && (panel_run_sw || (ext && (forward_run_input ||
                   reverse_run_input)));

  // locked shaft timer, restarted whenever the shaft moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_r <= 32'h0;
    end else if (!(shaft_locked && drive_enable)) begin
      lock_cnt_r <= 32'h0;
    end else if (lock_cnt_r < LOCK_CYC) begin
      lock_cnt_r <= lock_cnt_r + 32'h1;
    end
  end

  // alarm latch, first alarm held; reset clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_r    <= MSS_A_NONE;
      pon_done_r <= 1'b0;
    end else begin
      pon_done_r <= 1'b1;
      if (alarm_r == MSS_A_NONE) begin
        if (nvm_fault) begin
          alarm_r <= MSS_A_NVM;
        end else if (thermal_open) begin
          alarm_r <= MSS_A_HEAT;
        end else if (lock_cnt_r >= LOCK_CYC || feedback_lost) begin
          alarm_r <= MSS_A_LOCK;
        end else if (!pon_done_r && ctrl_r[`MSS_CTRL_PONP_BIT] &&
                     (panel_run_sw || forward_run_input || reverse_run_input)) begin
          alarm_r <= MSS_A_PON;
        end
      end else if (alarm_r == MSS_A_PON && !panel_run_sw && !forward_run_input &&
                   !reverse_run_input) begin
        alarm_r <= MSS_A_NONE;
      end else if (alrst_req && !rst_bad && !nvm_fault && !thermal_open) begin
        alarm_r <= MSS_A_NONE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_r     <= MSS_D_NORM;
      msg_cnt_r <= 32'h0;
    end else if (rst_bad) begin
      msg_r     <= MSS_D_ERR;
      msg_cnt_r <= MSG_CYC;
    end else if (ext && panel_poke) begin
      msg_r     <= MSS_D_EXT;
      msg_cnt_r <= MSG_CYC;
    end else if (locked_try) begin
      msg_r     <= MSS_D_LOCK;
      msg_cnt_r <= MSG_CYC;
    end else if (msg_cnt_r > 32'h1) begin
      msg_cnt_r <= msg_cnt_r - 32'h1;
    end else begin
      msg_r     <= MSS_D_NORM;
      msg_cnt_r <= 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_r <= 32'h0;
    end else if (key_activity) begin
      idle_cnt_r <= IDLE_CYC;
    end else if (idle_cnt_r != 32'h0) begin
      idle_cnt_r <= idle_cnt_r - 32'h1;
    end
  end

  // drive outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_enable  <= 1'b0;
      drive_reverse <= 1'b0;
    end else begin
      drive_enable  <= run_cmd && (alarm_r == MSS_A_NONE);
      drive_reverse <= ext ? reverse_run_input : dir_r;
    end
  end

  // ramp selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_time_ds <= 16'(`MSS_RAMP_FIX_DS);
    end else if (!ctrl_r[`MSS_CTRL_RAMP_BIT]) begin
      ramp_time_ds <= 16'(`MSS_RAMP_FIX_DS);
    end else begin
      ramp_time_ds <= (ramp_pot < 8'(`MSS_RAMP_MIN_DS)) ? 16'(`MSS_RAMP_MIN_DS) :
                      (ramp_pot > 8'(`MSS_RAMP_MAX_DS)) ? 16'(`MSS_RAMP_MAX_DS) :
                      {8'h0, ramp_pot};
    end
  end

  // display value and point
  logic [35:0] scaled;        // shaft speed times point scale
  logic [1:0]  point_nxt;     // digits after the point
  logic [19:0] scale_k;       // hundred times ten to the point
  // point by range, four digits for any ratio
  always_comb begin
    if (ratio_r < 20'd1000) begin
      point_nxt = 2'd0;
      scale_k   = 20'd100;
    end else if (ratio_r < 20'd10000) begin
      point_nxt = 2'd1;
      scale_k   = 20'd1000;
    end else if (ratio_r < 20'd100000) begin
      point_nxt = 2'd2;
      scale_k   = 20'd10000;
    end else begin
      point_nxt = 2'd3;
      scale_k   = 20'd100000;
    end
  end
  // product stays below 2**36 for any shaft speed
  assign scaled = {20'h0, shaft_speed} * {16'h0, scale_k};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_value  <= 16'h0;
      disp_point  <= 2'h0;
      disp_mode   <= 3'(MSS_D_NORM);
      alarm_code  <= 3'h0;
      alarm_blink <= 1'b0;
    end else begin
      // speed over ratio, in units of the point
      disp_value <= 16'(scaled / {16'h0, ratio_r});
      disp_point <= point_nxt;
      alarm_code  <= alarm_r;
      alarm_blink <= (alarm_r != MSS_A_NONE);
      if (msg_r != MSS_D_NORM) disp_mode <= msg_r;
      else if (alarm_r != MSS_A_NONE && idle_cnt_r == 32'h0) disp_mode <= MSS_D_ALM;
      else disp_mode <= MSS_D_NORM;
    end
  end
endmodule

// *** test/mss_ext_ctrl.sv ***
// Purpose: external controller on the forward and reverse inputs
// Assumes: cmd 0 off, 1 forward, 2 reverse, 3 both on
// Notes:   a new direction is applied only once the drive is off
`timescale 1ns/100ps
module mss_ext_ctrl (
  // clock
  input  wire logic       hclk,
  // bench command and drive state
  input  wire logic [1:0] cmd,
  input  wire logic       drive_enable,
  // link lines
  output logic            forward_run_input = 1'b0,
  output logic            reverse_run_input = 1'b0
);
  always @(posedge hclk) begin
    if ({reverse_run_input, forward_run_input} != cmd) begin
      if ({reverse_run_input, forward_run_input} != 2'h0) begin
        forward_run_input <= 1'b0;
        reverse_run_input <= 1'b0;
      end else if (!drive_enable) begin
        forward_run_input <= cmd[0];
        reverse_run_input <= cmd[1];
      end
    end
  end
endmodule

// *** test/mss_top_asserts.sv ***
// Purpose: port checks of the motor speed supervisor
// Assumes: one clock domain, bound to mss_top
// Notes:   lock count handed on from the bound instance
`timescale 1ns/100ps
module mss_top_asserts
  import mss_pkg::*;
#(
  parameter int unsigned LOCK_CYC = 30
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // watched inputs
  input wire logic        panel_run_sw,
  input wire logic        key_activity,
  input wire logic        forward_run_input,
  input wire logic        reverse_run_input,
  input wire logic        thermal_open,
  input wire logic        shaft_locked,
  input wire logic        nvm_fault,
  // watched outputs
  input wire logic        drive_enable,
  input wire logic [15:0] ramp_time_ds,
  input wire logic [2:0]  disp_mode,
  input wire logic [2:0]  alarm_code,
  input wire logic        alarm_blink
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] lk_cnt_r; // cycles of drive against a locked shaft
  // counts run time on a locked shaft, clears when either drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lk_cnt_r <= 16'h0;
    else if (drive_enable && shaft_locked) lk_cnt_r <= lk_cnt_r + 16'h1;
    else lk_cnt_r <= 16'h0;
  end
  alarm_off_a: assert property ((alarm_code != MSS_A_NONE) [*2] |-> !drive_enable)
    else $error("drive on while alarm latched");
  blink_follow_a: assert property (alarm_blink == (alarm_code != MSS_A_NONE))
    else $error("blink differs from alarm state");
  ramp_range_a: assert property (ramp_time_ds >= 16'd1 && ramp_time_ds <= 16'd150)
    else $error("ramp time out of range");
  run_cause_a: assert property (drive_enable |->
    $past(panel_run_sw || (forward_run_input ^ reverse_run_input)))
    else $error("drive on without a run cause");
  reset_clear_a: assert property ($rose(hresetn) |-> alarm_code == MSS_A_NONE)
    else $error("alarm survives reset");
  key_view_a: assert property (key_activity |-> ##2 disp_mode != MSS_D_ALM)
    else $error("alarm view during key use");
  lock_limit_a: assert property (lk_cnt_r <= LOCK_CYC + 4)
    else $error("locked shaft kept driven");
  heat_alarm_a: assert property (thermal_open |-> ##2 alarm_code != MSS_A_NONE)
    else $error("overheat not latched");
  mem_alarm_a: assert property (nvm_fault |-> ##2 alarm_code != MSS_A_NONE)
    else $error("memory fault not latched");
endmodule
bind mss_top mss_top_asserts #(.LOCK_CYC(LOCK_CYC)) mss_top_asserts_i (.*);

// *** test/mss_top_tb_top.sv ***
// Purpose: self-checking bench of the motor speed supervisor
// Assumes: shortened message, idle and lock counts
// Notes:   registers over ahb-lite, link through the controller model
`timescale 1ns/100ps
`include "mss_defs.svh"
module mss_top_tb_top
  import mss_pkg::*;
;
  localparam int MSG = 20, IDLE = 50, LOCK = 30;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, cmd = 2'h0, disp_point, pt [4];
  logic [2:0]  hsize = 3'h2, disp_mode, alarm_code;
  logic panel_run_sw = 1'b0, panel_dir_sw = 1'b0, key_activity = 1'b0, dial_change = 1'b0;
  logic thermal_open = 1'b0, shaft_locked = 1'b0, feedback_lost = 1'b0, nvm_fault = 1'b0;
  logic [15:0] dial_value = 16'h0, shaft_speed = 16'h0, ramp_time_ds, disp_value;
  logic [7:0]  ramp_pot = 8'h0;
  logic forward_run_input, reverse_run_input, drive_enable, drive_reverse, alarm_blink;
  logic [7:0]  pots [3] = '{8'd80, 8'd200, 8'd0};
  logic [15:0] rmps [3] = '{16'd80, 16'd150, 16'd1};
  logic [31:0] rats [4] = '{32'd100, 32'd1000, 32'd10000, 32'd100000};
  logic [1:0]  cmds [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  logic [1:0]  runs [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  int error_cnt = 0, num_checks = 0, cyc = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  mss_top #(.MSG_CYC(MSG), .IDLE_CYC(IDLE), .LOCK_CYC(LOCK)) mss_top_i (.*);
  mss_ext_ctrl mss_ext_ctrl_i (.*);
  // prints counts and verdict, ends the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // single word transfer: address phase, then data phase
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(string nm, logic [31:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
    chk("resp", 32'({hreadyout, hresp}), 32'h2);
  endtask
  // one dial step with a new setpoint
  task automatic dial(logic [15:0] v);
    @(posedge hclk);
    dial_change <= 1'b1;
    dial_value <= v;
    @(posedge hclk);
    dial_change <= 1'b0;
  endtask
  // cuts a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    wt(2);
    @(posedge hclk) hresetn <= 1'b1;
    rd("ctrl", `MSS_CTRL_OFF, 32'h8);
    rd("upper", `MSS_UPPER_OFF, 32'd1600);
    rd("lower", `MSS_LOWER_OFF, 32'd90);
    chk("ramp", 32'(ramp_time_ds), 32'd10);
    wr(`MSS_UPPER_OFF, 32'd800);
    rd("setpt", `MSS_SETPT_OFF, 32'd800);
    wr(`MSS_LOWER_OFF, 32'd900);
    rd("lower", `MSS_LOWER_OFF, 32'd90);
    wr(`MSS_UPPER_OFF, 32'd1601);
    rd("upper", `MSS_UPPER_OFF, 32'd800);
    wr(`MSS_UPPER_OFF, 32'd1600);
    wr(`MSS_LOWER_OFF, 32'd1200);
    rd("setpt", `MSS_SETPT_OFF, 32'd1200);
    dial(16'd50);
    rd("setpt", `MSS_SETPT_OFF, 32'd1200);
    dial(16'd1700);
    rd("setpt", `MSS_SETPT_OFF, 32'd1600);
    wr(`MSS_CTRL_OFF, 32'h9);
    dial(16'd1300);
    wt(2);
    chk("lockmsg", 32'(disp_mode), 32'(MSS_D_LOCK));
    wt(MSG + 2);
    chk("normal", 32'(disp_mode), 32'(MSS_D_NORM));
    wr(`MSS_UPPER_OFF, 32'd900);
    rd("upper", `MSS_UPPER_OFF, 32'd1600);
    rd("setpt", `MSS_SETPT_OFF, 32'd1600);
    rd("unmap", 32'h20, 32'h0);
    wr(`MSS_CTRL_OFF, 32'hc);
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk) ramp_pot <= pots[i];
      wt(3);
      chk("ramp", 32'(ramp_time_ds), 32'(rmps[i]));
    end
    wr(`MSS_RATIO_OFF, 32'd99);
    rd("ratio", `MSS_RATIO_OFF, 32'd100);
    @(posedge hclk) shaft_speed <= 16'd1300;
    wr(`MSS_RATIO_OFF, 32'd7960);
    wt(3);
    chk("disp", 32'(disp_value), 32'd163);
    chk("dpoint", 32'(disp_point), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`MSS_RATIO_OFF, rats[i]);
      wt(3);
      pt[i] = disp_point;
    end
    for (int i = 0; i < 3; i++) chk("point", 32'(pt[i] != pt[i+1]), 32'h1);
    wr(`MSS_CTRL_OFF, 32'ha);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk) cmd <= cmds[i];
      wt(8);
      chk("run", 32'({drive_enable, drive_reverse}), 32'(runs[i]));
    end
    @(posedge hclk) panel_dir_sw <= 1'b1;
    wt(2);
    chk("extmsg", 32'({disp_mode, drive_enable, drive_reverse}), 32'({MSS_D_EXT, 2'h3}));
    @(posedge hclk) thermal_open <= 1'b1;
    wt(3);
    chk("heat", 32'({drive_enable, alarm_code}), 32'({1'b0, MSS_A_HEAT}));
    @(posedge hclk) thermal_open <= 1'b0;
    wt(4);
    chk("heat2", 32'({drive_enable, alarm_blink, alarm_code}), 32'({2'h1, MSS_A_HEAT}));
    wr(`MSS_ALRST_OFF, 32'h1);
    wt(1);
    chk("rstext", 32'({disp_mode, alarm_code}), 32'({MSS_D_ERR, MSS_A_HEAT}));
    wt(MSG + 5);
    chk("almview", 32'(disp_mode), 32'(MSS_D_ALM));
    @(posedge hclk) key_activity <= 1'b1;
    @(posedge hclk) key_activity <= 1'b0;
    wt(2);
    chk("keyview", 32'(disp_mode == MSS_D_ALM), 32'h0);
    wt(IDLE + 3);
    chk("almback", 32'(disp_mode), 32'(MSS_D_ALM));
    @(posedge hclk) cmd <= 2'h0;
    wt(4);
    wr(`MSS_ALRST_OFF, 32'h1);
    wt(1);
    chk("rstok", 32'(alarm_code), 32'(MSS_A_NONE));
    wr(`MSS_CTRL_OFF, 32'h8);
    @(posedge hclk) panel_run_sw <= 1'b1;
    wt(3);
    chk("panel", 32'(drive_enable), 32'h1);
    @(posedge hclk) shaft_locked <= 1'b1;
    wt(LOCK + 6);
    chk("lock", 32'({drive_enable, alarm_code}), 32'({1'b0, MSS_A_LOCK}));
    wr(`MSS_ALRST_OFF, 32'h1);
    wt(1);
    chk("rstrun", 32'({disp_mode, alarm_code}), 32'({MSS_D_ERR, MSS_A_LOCK}));
    @(posedge hclk) panel_run_sw <= 1'b0;
    shaft_locked <= 1'b0;
    wr(`MSS_ALRST_OFF, 32'h1);
    wt(1);
    chk("rstok2", 32'(alarm_code), 32'(MSS_A_NONE));
    @(posedge hclk) nvm_fault <= 1'b1;
    wt(3);
    chk("nvm", 32'(alarm_code), 32'(MSS_A_NVM));
    @(posedge hclk) nvm_fault <= 1'b0;
    panel_run_sw <= 1'b1;
    hresetn <= 1'b0;
    wt(2);
    @(posedge hclk) hresetn <= 1'b1;
    wt(3);
    chk("pon", 32'(alarm_code), 32'(MSS_A_PON));
    @(posedge hclk) panel_run_sw <= 1'b0;
    wt(3);
    chk("ponclr", 32'(alarm_code), 32'(MSS_A_NONE));
    give_verdict();
  end
endmodule
